// ==== pkg/fixcorr_pkg.sv ====
// Package: constants and types for fixture correction and limit binning
package fixcorr_pkg;

   // ***********************************************************
   // Widths and thresholds
   // ***********************************************************
   localparam int unsigned VAL_W            = 32;
   // Open admittance limit in microsiemens (values carried in uS)
   localparam logic [31:0] OPEN_LIMIT_US    = 32'h0000_0064;
   // Short impedance limit in milliohms (10 ohm)
   localparam logic [31:0] SHORT_LIMIT_MOHM = 32'h0000_2710;
   // Load deviation limit in percent
   localparam logic [7:0]  LOAD_DEV_PCT     = 8'h14;
   localparam logic [7:0]  PCT_FULL         = 8'h64;
   // Forced measurement settings for correction sweeps
   localparam logic [3:0]  CORR_AVG_RATE    = 4'h1;
   localparam logic [15:0] CORR_TRIG_DLY_MS = 16'h0000;
   localparam logic [1:0]  MTIME_LONG       = 2'h2;

   // ***********************************************************
   // Status and comparison codes
   // ***********************************************************
   localparam logic [1:0]  STAT_NORMAL      = 2'h0;
   localparam logic [1:0]  STAT_NO_CONTACT  = 2'h2;
   localparam logic [3:0]  CMP_OFF          = 4'h0;
   localparam logic [3:0]  CMP_IN           = 4'h1;
   localparam logic [3:0]  CMP_HIGH         = 4'h2;
   localparam logic [3:0]  CMP_LOW          = 4'h4;
   localparam logic [3:0]  CMP_NC           = 4'h8;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef enum logic [1:0] {BEEP_OFF, BEEP_PASS, BEEP_FAIL} beep_mode_e;

   typedef enum logic [2:0] {
      KEY_NONE, KEY_UP, KEY_DOWN, KEY_CONFIRM, KEY_OPEN, KEY_SHORT, KEY_LOAD
   } key_e;

   typedef struct packed {
      logic                  force_bias_off;
      logic                  auto_range;
      logic [1:0]            meas_time;
      logic [3:0]            avg_rate;
      logic [15:0]           trig_delay_ms;
      logic                  sweep_all_freq;
   } meas_cfg_s;

   typedef struct packed {
      logic                  valid;
      logic [VAL_W-1:0]      value;
      logic [VAL_W-1:0]      lower;
      logic [VAL_W-1:0]      upper;
      logic                  contact_fail;
   } result_s;

   typedef struct packed {
      logic                  valid;
      logic [3:0]            code;
   } bin_s;

endpackage

// ==== design/limit_binner.sv ====
// Module: compares one result against its limits and forms the bin code
`timescale 1ns/1ps
module limit_binner
   import fixcorr_pkg::*;
(
   input  wire  logic                   core_clk,
   input  wire  logic                   rst_n,
   input  wire  logic                   comp_on,
   input  wire  logic                   contact_check_on,
   input  wire  fixcorr_pkg::result_s   res,
   output logic                         bin_valid_ff,
   output logic [3:0]                   bin_code_ff
);

   wire         is_high   = res.value > res.upper;
   wire         is_low    = res.value < res.lower;
   wire         nc        = contact_check_on && res.contact_fail;
   // Equal to a limit falls through to in-band
   wire [3:0]   limit_cmp = is_high ? CMP_HIGH : (is_low ? CMP_LOW : CMP_IN);
   wire [3:0]   nxt_code  = nc ? CMP_NC : limit_cmp;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bin_valid_ff <= 1'b0;
         bin_code_ff  <= CMP_OFF;
      end else begin
         bin_valid_ff <= res.valid && comp_on;
         bin_code_ff  <= comp_on ? nxt_code : CMP_OFF;
      end
   end

endmodule // limit_binner

// ==== design/fixture_corr_bin.sv ====
// Module: fixture correction menus, warnings and comparator binning
`timescale 1ns/1ps
module fixture_corr_bin
   import fixcorr_pkg::*;
(
   input  wire  logic                     core_clk,
   input  wire  logic                     rst_n,
   // Operator
   input  wire  fixcorr_pkg::key_e        key_cmd,
   input  wire  logic                     comp_key,
   input  wire  logic [1:0]               entry_code,
   input  wire  logic [31:0]              entry_value,
   input  wire  logic                     param_changed,
   input  wire  logic                     dev_mode_changed,
   input  wire  logic                     full_reset,
   input  wire  logic                     std_reset,
   input  wire  logic                     remote_corr_set,
   input  wire  logic                     remote_corr_val,
   input  wire  logic                     contact_check_on,
   input  wire  fixcorr_pkg::beep_mode_e  beep_mode,
   // Measurement engine
   input  wire  logic                     meas_done,
   input  wire  logic [31:0]              meas_pri,
   input  wire  logic [31:0]              meas_sec,
   input  wire  fixcorr_pkg::result_s     result,
   // Outputs
   output fixcorr_pkg::meas_cfg_s         meas_cfg_ff,
   output logic                           meas_start_ff,
   output logic [1:0]                     meas_kind_ff,
   output logic                           show_valid_ff,
   output logic [31:0]                    show_value_ff,
   output logic                           warn_ff,
   output logic                           corr_on_ff,
   output logic                           load_on_ff,
   output logic                           comp_on_ff,
   output logic [1:0]                     load_pri_model_ff,
   output logic [1:0]                     load_sec_model_ff,
   output logic                           disp_valid_ff,
   output logic [3:0]                     disp_code_ff,
   output logic [3:0]                     handler_code_ff,
   output logic                           handler_nc_ff,
   output logic [1:0]                     meas_status_ff,
   output logic                           beep_ff
);

   // ***********************************************************
   // Menu state
   // ***********************************************************
   typedef enum logic [3:0] {
      M_IDLE, M_OPEN, M_SHORT, M_LOAD, M_LOAD_ONOFF, M_LOAD_VAL,
      M_SEL_PRI, M_SEL_SEC, M_REF_PRI, M_REF_SEC, M_MEAS, M_SHOW
   } menu_e;

   menu_e       menu_ff, nxt_menu, ret_ff;
   logic [2:0]  item_ff;
   logic        show_sec_ff;
   logic [1:0]  kind_ff;
   // Nonvolatile correction image (held in flip-flops here)
   logic [31:0] open_g_ff, open_b_ff, short_r_ff, short_x_ff;
   logic [31:0] load_p_ff, load_s_ff, ref_p_ff, ref_s_ff;

   function automatic logic over_dev(input logic [31:0] m, input logic [31:0] r);
      logic [39:0] diff;
      logic [39:0] lim;
      diff = (m > r) ? {8'h00, m - r} : {8'h00, r - m};
      lim  = 40'(r) * 40'(LOAD_DEV_PCT);
      over_dev = (40'(diff) * 40'(PCT_FULL)) > lim;
   endfunction

   wire key_up   = key_cmd == KEY_UP;
   wire key_conf = key_cmd == KEY_CONFIRM;
   wire [2:0] nxt_item = key_up ? item_ff + 3'h1 : item_ff;
   wire [2:0] item_max = (menu_ff == M_LOAD) ? 3'h3 :
                         (menu_ff == M_LOAD_VAL) ? 3'h3 : 3'h2;
   wire [2:0] item_w   = (key_up && item_ff == item_max) ? 3'h0 : nxt_item;

   // Menu next state; open/short item 0 = measure, 1 = show, 2 = exit; load item 0 = onoff, 1 = measure, 2 = value, 3 = exit
   always_comb begin
      nxt_menu = menu_ff;
      case (menu_ff)
         M_IDLE: begin
            if (key_cmd == KEY_OPEN) nxt_menu = M_OPEN;
            else if (key_cmd == KEY_SHORT) nxt_menu = M_SHORT;
            else if (key_cmd == KEY_LOAD) nxt_menu = M_LOAD;
         end
         M_OPEN, M_SHORT: begin
            if (key_conf) begin
               case (item_ff)
                  3'h0:    nxt_menu = M_MEAS;
                  3'h1:    nxt_menu = M_SHOW;
                  default: nxt_menu = M_IDLE;
               endcase
            end
         end
         M_LOAD: begin
            if (key_conf) begin
               case (item_ff)
                  3'h0:    nxt_menu = M_LOAD_ONOFF;
                  3'h1:    nxt_menu = M_MEAS;
                  3'h2:    nxt_menu = M_LOAD_VAL;
                  default: nxt_menu = M_IDLE;
               endcase
            end
         end
         M_LOAD_ONOFF: if (key_conf) nxt_menu = M_LOAD;
         M_LOAD_VAL: begin
            if (key_conf) begin
               case (item_ff)
                  3'h0:    nxt_menu = M_SEL_PRI;
                  3'h1:    nxt_menu = M_REF_PRI;
                  3'h2:    nxt_menu = M_SHOW;
                  default: nxt_menu = M_LOAD;
               endcase
            end
         end
         M_SEL_PRI: if (key_conf) nxt_menu = M_SEL_SEC;
         M_SEL_SEC: if (key_conf) nxt_menu = M_LOAD_VAL;
         M_REF_PRI: if (key_conf) nxt_menu = M_REF_SEC;
         M_REF_SEC: if (key_conf) nxt_menu = M_LOAD_VAL;
         M_MEAS:    if (meas_done) nxt_menu = ret_ff;
         M_SHOW:    if (key_conf && show_sec_ff) nxt_menu = ret_ff;
         default:   nxt_menu = M_IDLE;
      endcase
   end

   wire enter_meas = nxt_menu == M_MEAS && menu_ff != M_MEAS;
   wire enter_show = nxt_menu == M_SHOW && menu_ff != M_SHOW;
   wire [1:0] kind_now = (menu_ff == M_OPEN) ? 2'h0 :
                         (menu_ff == M_SHORT) ? 2'h1 : 2'h2;
   wire open_warn  = meas_pri >= OPEN_LIMIT_US;
   wire short_warn = meas_pri >= SHORT_LIMIT_MOHM;
   wire load_warn  = over_dev(meas_pri, ref_p_ff) || over_dev(meas_sec, ref_s_ff);
   wire done_now   = menu_ff == M_MEAS && meas_done;
   wire [31:0] sel_pri = (kind_ff == 2'h0) ? open_g_ff :
                         (kind_ff == 2'h1) ? short_r_ff : load_p_ff;
   wire [31:0] sel_sec = (kind_ff == 2'h0) ? open_b_ff :
                         (kind_ff == 2'h1) ? short_x_ff : load_s_ff;

   // ***********************************************************
   // Menu and measurement control
   // ***********************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         menu_ff       <= M_IDLE;
         ret_ff        <= M_IDLE;
         item_ff       <= 3'h0;
         kind_ff       <= 2'h0;
         show_sec_ff   <= 1'b0;
         meas_start_ff <= 1'b0;
         meas_kind_ff  <= 2'h0;
         meas_cfg_ff   <= '0;
      end else begin
         menu_ff       <= nxt_menu;
         item_ff       <= (nxt_menu != menu_ff) ? 3'h0 : item_w;
         meas_start_ff <= enter_meas;
         if (enter_meas || enter_show) begin
            ret_ff  <= (menu_ff == M_LOAD_VAL) ? M_LOAD_VAL : menu_ff;
            kind_ff <= kind_now;
         end
         if (enter_meas) begin
            meas_kind_ff <= kind_now;
            meas_cfg_ff  <= '{force_bias_off: 1'b1, auto_range: 1'b1,
                              meas_time: MTIME_LONG, avg_rate: CORR_AVG_RATE,
                              trig_delay_ms: CORR_TRIG_DLY_MS,
                              sweep_all_freq: kind_now != 2'h2};
         end
         if (enter_show) show_sec_ff <= 1'b0;
         else if (menu_ff == M_SHOW && key_conf) show_sec_ff <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         show_valid_ff <= 1'b0;
         show_value_ff <= 32'h0000_0000;
      end else begin
         show_valid_ff <= menu_ff == M_SHOW;
         show_value_ff <= show_sec_ff ? sel_sec : sel_pri;
      end
   end

   // ***********************************************************
   // Correction store; std_reset deliberately untouched here
   // ***********************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {open_g_ff, open_b_ff, short_r_ff, short_x_ff} <= '0;
         {load_p_ff, load_s_ff, ref_p_ff, ref_s_ff}     <= '0;
         load_pri_model_ff <= 2'h0;
         load_sec_model_ff <= 2'h0;
         warn_ff           <= 1'b0;
      end else if (full_reset) begin
         {open_g_ff, open_b_ff, short_r_ff, short_x_ff} <= '0;
         {load_p_ff, load_s_ff, ref_p_ff, ref_s_ff}     <= '0;
         warn_ff <= 1'b0;
      end else begin
         if (done_now) begin
            // Warning only; data is stored regardless
            case (kind_ff)
               2'h0: begin
                  {open_g_ff, open_b_ff} <= {meas_pri, meas_sec};
                  warn_ff <= open_warn;
               end
               2'h1: begin
                  {short_r_ff, short_x_ff} <= {meas_pri, meas_sec};
                  warn_ff <= short_warn;
               end
               default: begin
                  {load_p_ff, load_s_ff} <= {meas_pri, meas_sec};
                  warn_ff <= load_warn;
               end
            endcase
         end else if (key_cmd != KEY_NONE) begin
            warn_ff <= 1'b0;
         end
         if (key_conf && menu_ff == M_SEL_PRI) load_pri_model_ff <= entry_code;
         if (key_conf && menu_ff == M_SEL_SEC) load_sec_model_ff <= entry_code;
         if (key_conf && menu_ff == M_REF_PRI) ref_p_ff <= entry_value;
         if (key_conf && menu_ff == M_REF_SEC) ref_s_ff <= entry_value;
      end
   end

   // ***********************************************************
   // Correction, load and comparator switches
   // ***********************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         corr_on_ff <= 1'b1;
         load_on_ff <= 1'b0;
         comp_on_ff <= 1'b0;
      end else begin
         if (remote_corr_set) corr_on_ff <= remote_corr_val;
         else if (std_reset) corr_on_ff <= 1'b0;
         else if (full_reset) corr_on_ff <= 1'b1;
         if (menu_ff == M_LOAD_ONOFF && key_conf) load_on_ff <= item_ff == 3'h0;
         else if (menu_ff == M_LOAD_ONOFF && key_cmd == KEY_DOWN) load_on_ff <= 1'b0;
         if (param_changed || dev_mode_changed || full_reset || std_reset)
            comp_on_ff <= 1'b0;
         else if (comp_key)
            comp_on_ff <= ~comp_on_ff;
      end
   end

   // ***********************************************************
   // Binning and outcome routing
   // ***********************************************************
   logic       bin_valid;
   logic [3:0] bin_code;

   limit_binner u_binner (
      .core_clk         (core_clk),
      .rst_n            (rst_n),
      .comp_on          (comp_on_ff),
      .contact_check_on (contact_check_on),
      .res              (result),
      .bin_valid_ff     (bin_valid),
      .bin_code_ff      (bin_code)
   );

   wire nc_now   = result.valid && contact_check_on && result.contact_fail;
   wire is_fail  = bin_code != CMP_IN;
   wire nxt_beep = bin_valid &&
                   ((beep_mode == BEEP_FAIL && is_fail) ||
                    (beep_mode == BEEP_PASS && !is_fail));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         disp_valid_ff   <= 1'b0;
         disp_code_ff    <= CMP_OFF;
         handler_code_ff <= CMP_OFF;
         handler_nc_ff   <= 1'b0;
         meas_status_ff  <= STAT_NORMAL;
         beep_ff         <= 1'b0;
      end else begin
         disp_valid_ff   <= bin_valid;
         disp_code_ff    <= bin_code;
         handler_code_ff <= bin_code;
         beep_ff         <= nxt_beep;
         if (result.valid) begin
            handler_nc_ff  <= nc_now;
            meas_status_ff <= nc_now ? STAT_NO_CONTACT : STAT_NORMAL;
         end
      end
   end

endmodule // fixture_corr_bin

// ==== bench/meas_engine_model.sv ====
// Partner model: measurement engine that answers correction sweeps
`timescale 1ns/1ps
module meas_engine_model (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        meas_start,
   input  wire logic [7:0]  delay,
   input  wire logic [31:0] pri_val,
   input  wire logic [31:0] sec_val,
   output logic             meas_done,
   output logic [31:0]      meas_pri,
   output logic [31:0]      meas_sec
);
   logic [7:0] cnt_ff;
   // Data lines toggle outside the done pulse so stale values never match
   always @(negedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 8'h00;
         meas_done <= 1'b0;
         meas_pri <= 32'h0;
         meas_sec <= 32'h0;
      end else begin
         meas_done <= 1'b0;
         meas_pri <= ~meas_pri;
         meas_sec <= ~meas_sec;
         if (meas_start) begin
            cnt_ff <= delay;
         end else if (cnt_ff == 8'h01) begin
            meas_done <= 1'b1;
            meas_pri <= pri_val;
            meas_sec <= sec_val;
            cnt_ff <= 8'h00;
         end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end
endmodule // meas_engine_model

// ==== bench/fixture_corr_bin_props.sv ====
// Checker: port assertions for correction control and limit binning
`timescale 1ns/1ps
module fixture_corr_bin_props
   import fixcorr_pkg::*;
(
   input wire logic                   core_clk,
   input wire logic                   rst_n,
   input wire logic                   comp_key,
   input wire logic                   param_changed,
   input wire logic                   dev_mode_changed,
   input wire logic                   full_reset,
   input wire logic                   std_reset,
   input wire logic                   remote_corr_set,
   input wire logic                   remote_corr_val,
   input wire logic                   contact_check_on,
   input wire fixcorr_pkg::beep_mode_e beep_mode,
   input wire fixcorr_pkg::result_s   result,
   input wire fixcorr_pkg::meas_cfg_s meas_cfg_ff,
   input wire logic                   meas_start_ff,
   input wire logic                   corr_on_ff,
   input wire logic                   comp_on_ff,
   input wire logic                   disp_valid_ff,
   input wire logic [3:0]             disp_code_ff,
   input wire logic [3:0]             handler_code_ff,
   input wire logic                   handler_nc_ff,
   input wire logic [1:0]             meas_status_ff,
   input wire logic                   beep_ff
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire nc_hit = result.valid && contact_check_on && result.contact_fail;
   // Lower above upper is left unchecked on purpose
   wire scored = result.valid && comp_on_ff && !nc_hit && result.lower <= result.upper;
   wire resets = full_reset || std_reset;

   in_band_a: assert property (scored && result.value >= result.lower && result.value <= result.upper ##1 comp_on_ff |=> disp_valid_ff && disp_code_ff == CMP_IN && handler_code_ff == CMP_IN) else $error("in-band bin wrong");
   high_bin_a: assert property (scored && result.value > result.upper ##1 comp_on_ff |=> disp_code_ff == CMP_HIGH && handler_code_ff == CMP_HIGH) else $error("high bin wrong");
   low_bin_a: assert property (scored && result.value < result.lower ##1 comp_on_ff |=> disp_code_ff == CMP_LOW && handler_code_ff == CMP_LOW) else $error("low bin wrong");
   nc_code_a: assert property (nc_hit && comp_on_ff ##1 comp_on_ff |=> disp_code_ff == CMP_NC && handler_code_ff == CMP_NC) else $error("no-contact bin wrong");
   nc_status_a: assert property (nc_hit |=> handler_nc_ff && meas_status_ff == STAT_NO_CONTACT) else $error("no-contact status wrong");
   comp_off_a: assert property (result.valid && !comp_on_ff ##1 !comp_on_ff |=> !disp_valid_ff && !beep_ff && disp_code_ff == CMP_OFF) else $error("output while comparator off");
   beep_mode_a: assert property (disp_valid_ff && $past(beep_mode) == beep_mode && $past(beep_mode, 2) == beep_mode |-> beep_ff == (beep_mode == BEEP_PASS ? disp_code_ff == CMP_IN : beep_mode == BEEP_FAIL && disp_code_ff != CMP_IN)) else $error("beep does not follow mode");
   beep_off_a: assert property (beep_mode == BEEP_OFF && $past(beep_mode) == BEEP_OFF && $past(beep_mode, 2) == BEEP_OFF |-> !beep_ff) else $error("beep in off mode");
   comp_toggle_a: assert property (comp_key && !param_changed && !dev_mode_changed && !resets |=> comp_on_ff != $past(comp_on_ff)) else $error("comparator key no toggle");
   comp_auto_off_a: assert property (param_changed || dev_mode_changed |=> !comp_on_ff) else $error("comparator not forced off");
   corr_state_a: assert property (remote_corr_set || !resets |=> corr_on_ff == ($past(remote_corr_set) ? $past(remote_corr_val) : $past(corr_on_ff))) else $error("correction state moved");
   forced_cfg_a: assert property (meas_start_ff |-> meas_cfg_ff.force_bias_off && meas_cfg_ff.auto_range && meas_cfg_ff.meas_time == MTIME_LONG && meas_cfg_ff.avg_rate == CORR_AVG_RATE && meas_cfg_ff.trig_delay_ms == CORR_TRIG_DLY_MS) else $error("forced settings wrong");

   cover property (nc_hit && comp_on_ff);
   cover property (disp_valid_ff && disp_code_ff == CMP_HIGH);
   cover property (beep_ff);
endmodule // fixture_corr_bin_props

bind fixture_corr_bin fixture_corr_bin_props chk_i (.core_clk, .rst_n, .comp_key,
   .param_changed, .dev_mode_changed, .full_reset, .std_reset, .remote_corr_set,
   .remote_corr_val, .contact_check_on, .beep_mode, .result, .meas_cfg_ff, .meas_start_ff,
   .corr_on_ff, .comp_on_ff, .disp_valid_ff, .disp_code_ff, .handler_code_ff,
   .handler_nc_ff, .meas_status_ff, .beep_ff);

// ==== bench/tb_fixture_correction_and_limit_binning.sv ====
// Testbench: self-checking bench for correction menus and binning
`timescale 1ns/1ps
module tb_fixture_correction_and_limit_binning
   import fixcorr_pkg::*;
;
   logic core_clk, rst_n, comp_key, param_changed, dev_mode_changed, full_reset, std_reset;
   logic remote_corr_set, remote_corr_val, contact_check_on, meas_done, comp_m;
   logic meas_start_ff, show_valid_ff, warn_ff, corr_on_ff, load_on_ff, comp_on_ff;
   logic disp_valid_ff, handler_nc_ff, beep_ff;
   logic [1:0] entry_code, meas_kind_ff, load_pri_model_ff, load_sec_model_ff, meas_status_ff;
   logic [3:0] disp_code_ff, handler_code_ff;
   logic [7:0] delay;
   logic [31:0] entry_value, meas_pri, meas_sec, pri_val, sec_val, show_value_ff, v, l, u;
   key_e key_cmd;
   beep_mode_e beep_mode;
   result_s result;
   meas_cfg_s meas_cfg_ff;
   int seed, i, mismatches, num_checks;

   fixture_corr_bin dut (.core_clk, .rst_n, .key_cmd, .comp_key, .entry_code, .entry_value,
      .param_changed, .dev_mode_changed, .full_reset, .std_reset, .remote_corr_set,
      .remote_corr_val, .contact_check_on, .beep_mode, .meas_done, .meas_pri, .meas_sec,
      .result, .meas_cfg_ff, .meas_start_ff, .meas_kind_ff, .show_valid_ff, .show_value_ff,
      .warn_ff, .corr_on_ff, .load_on_ff, .comp_on_ff, .load_pri_model_ff, .load_sec_model_ff,
      .disp_valid_ff, .disp_code_ff, .handler_code_ff, .handler_nc_ff, .meas_status_ff,
      .beep_ff);
   meas_engine_model partner (.core_clk, .rst_n, .meas_start(meas_start_ff), .delay, .pri_val,
      .sec_val, .meas_done, .meas_pri, .meas_sec);

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ***********************************************************
   // Tasks
   // ***********************************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic key(input key_e k);
      @(negedge core_clk) key_cmd = k;
      @(negedge core_clk) key_cmd = KEY_NONE;
   endtask

   task automatic pulse(ref logic s);
      @(negedge core_clk) s = 1'b1;
      @(negedge core_clk) s = 1'b0;
   endtask

   // Bin model: no-contact wins, then high, then low, limits count in-band
   task automatic send(input logic [31:0] rv, rl, ru, input logic cf);
      logic nc;
      logic [3:0] c;
      @(negedge core_clk) result = '{1'b1, rv, rl, ru, cf};
      @(negedge core_clk) result.valid = 1'b0;
      nc = contact_check_on && cf;
      c = !comp_m ? CMP_OFF : nc ? CMP_NC : rv > ru ? CMP_HIGH : rv < rl ? CMP_LOW : CMP_IN;
      @(negedge core_clk);
      chk(handler_nc_ff, nc);
      chk(meas_status_ff, nc ? STAT_NO_CONTACT : STAT_NORMAL);
      chk(disp_valid_ff, comp_m);
      chk(disp_code_ff, c);
      chk(handler_code_ff, c);
      chk(beep_ff, comp_m && (beep_mode == BEEP_PASS ? c == CMP_IN : beep_mode == BEEP_FAIL && c != CMP_IN));
   endtask

   // Show item: primary, then secondary, then back and exit
   task automatic show(input logic [31:0] p, s);
      key(KEY_UP);
      chk(warn_ff, 1'b0);
      key(KEY_CONFIRM);
      @(negedge core_clk);
      chk(show_value_ff, p);
      chk(show_valid_ff, 1'b1);
      key(KEY_CONFIRM);
      @(negedge core_clk);
      chk(show_value_ff, s);
      key(KEY_CONFIRM);
      repeat (2) key(KEY_UP);
      key(KEY_CONFIRM);
   endtask

   task automatic meas(input key_e k, input logic [31:0] p, s, input logic w, input logic [7:0] d);
      int n;
      pri_val = p;
      sec_val = s;
      delay = d;
      key(k);
      if (k == KEY_LOAD) key(KEY_UP);
      key(KEY_CONFIRM);
      for (n = 0; n < 20 && meas_start_ff !== 1'b1; n++) @(negedge core_clk);
      chk(n < 20, 1'b1);
      chk(meas_kind_ff, k == KEY_LOAD ? 2'h2 : {1'b0, k == KEY_SHORT});
      chk(meas_cfg_ff, meas_cfg_s'{1'b1, 1'b1, MTIME_LONG, CORR_AVG_RATE, CORR_TRIG_DLY_MS,
                                   k != KEY_LOAD});
      for (n = 0; n < 60 && meas_done !== 1'b1; n++) @(negedge core_clk);
      chk(n < 60, 1'b1);
      repeat (2) @(negedge core_clk);
      chk(warn_ff, w);
      if (k != KEY_LOAD) show(p, s);
   endtask

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      seed = 11;
      {comp_key, param_changed, dev_mode_changed, full_reset, std_reset} = 5'h00;
      {remote_corr_set, remote_corr_val, contact_check_on, comp_m, rst_n} = 5'h00;
      {entry_code, entry_value, pri_val, sec_val, delay} = '0;
      key_cmd = KEY_NONE;
      beep_mode = BEEP_OFF;
      result = '0;
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      chk(corr_on_ff, 1'b1);
      chk(comp_on_ff, 1'b0);
      pulse(comp_key);
      comp_m = 1'b1;
      @(negedge core_clk);
      chk(comp_on_ff, 1'b1);
      for (i = 0; i < 30; i++) begin
         beep_mode = beep_mode_e'(2'(i % 3));
         contact_check_on = i[2];
         l = 32'h64 + 32'($random(seed) & 255);
         u = l + 32'($random(seed) & 255);
         case (i % 5)
            0: v = l;
            1: v = u;
            2: v = u + 32'h1;
            3: v = l - 32'h1;
            default: v = l + 32'($random(seed) & 511);
         endcase
         send(v, l, u, 1'($random(seed)));
         if (i == 20) begin
            pulse(comp_key);
            comp_m = 1'b0;
         end
      end
      for (i = 0; i < 2; i++) begin
         pulse(comp_key);
         if (i == 0) pulse(param_changed);
         else pulse(dev_mode_changed);
         @(negedge core_clk);
         chk(comp_on_ff, 1'b0);
         send(32'h12c, 32'h64, 32'hc8, 1'b0);
      end
      for (i = 0; i < 4; i++) begin
         meas(i < 2 ? KEY_OPEN : KEY_SHORT, (i < 2 ? OPEN_LIMIT_US : SHORT_LIMIT_MOHM) - 32'h1 + 32'(i % 2), 32'(i * 7 + 3), 1'(i % 2), i[0] ? 8'h19 : 8'h01);
      end
      pulse(std_reset);
      @(negedge core_clk);
      chk(corr_on_ff, 1'b0);
      key(KEY_SHORT);
      show(SHORT_LIMIT_MOHM, 32'h18);
      pulse(full_reset);
      @(negedge core_clk);
      chk(corr_on_ff, 1'b1);
      pulse(remote_corr_set);
      @(negedge core_clk);
      chk(corr_on_ff, 1'b0);
      key(KEY_OPEN);
      show(32'h0, 32'h0);
      chk(corr_on_ff, 1'b0);
      key(KEY_LOAD);
      repeat (2) key(KEY_CONFIRM);
      chk(load_on_ff, 1'b1);
      repeat (2) key(KEY_UP);
      entry_code = 2'h1;
      entry_value = 32'h3e8;
      repeat (4) key(KEY_CONFIRM);
      key(KEY_UP);
      repeat (3) key(KEY_CONFIRM);
      chk({load_pri_model_ff, load_sec_model_ff}, 32'h5);
      repeat (3) key(KEY_UP);
      key(KEY_CONFIRM);
      repeat (3) key(KEY_UP);
      key(KEY_CONFIRM);
      meas(KEY_LOAD, 32'h4b1, 32'h3e8, 1'b1, 8'h03);
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      end_of_test();
   end
endmodule // tb_fixture_correction_and_limit_binning
